// ===== design/vsg_pkg.sv
package vsg_pkg;
	// ************************************************
	// widths and limits
	// ************************************************
	localparam int VL_W = 8;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int REG_W = 5;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W = REG_W + VL_W + DATA_W;
	localparam logic [6:0] MAX_SPAN = 7'h08;
	localparam logic [6:0] REG_COUNT = 7'h20;
	localparam logic signed [3:0] LOG_MAX = 4'sh3;
	localparam logic signed [3:0] LOG_MIN = -4'sh3;
	localparam logic [4:0] MASK_REG = 5'h00;
	// ************************************************
	// encodings
	// ************************************************
	localparam logic [1:0] MODE_UNIT = 2'h0;
	localparam logic [1:0] MODE_STRIDE = 2'h1;
	localparam logic [1:0] MODE_IDX_UNORD = 2'h2;
	localparam logic [1:0] MODE_IDX_ORD = 2'h3;
	localparam logic [1:0] TRAP_NONE = 2'h0;
	localparam logic [1:0] TRAP_FAULT = 2'h1;
	localparam logic [1:0] TRAP_IRQ = 2'h2;
	localparam logic [1:0] TRAP_DEBUG = 2'h3;
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_SEG = 8'h02,
		ST_MASK = 8'h04,
		ST_INDEX = 8'h08,
		ST_DATA = 8'h10,
		ST_ISSUE = 8'h20,
		ST_RSP = 8'h40,
		ST_DONE = 8'h80
	} vsg_state_t;
	// ************************************************
	// decode helpers
	// ************************************************
	function automatic logic [3:0] nf_decode(input logic [2:0] code);
		return 4'({1'b0, code} + 4'h1);
	endfunction
	function automatic logic [3:0] grp_regs(input logic signed [3:0] lg);
		return (lg <= 4'sh0) ? 4'h1 : 4'(4'h1 << lg[1:0]);
	endfunction
	function automatic logic grp_ok(input logic [4:0] base, input logic signed [3:0] lg,
			input logic [3:0] nf);
		logic [3:0] regs;
		logic [6:0] span;
		regs = grp_regs(lg);
		span = 7'(7'(regs) * 7'(nf));
		return (lg <= LOG_MAX) && (lg >= LOG_MIN) && (span <= MAX_SPAN)
			&& ((base & 5'(regs - 4'h1)) == 5'h00)
			&& (7'(base) + span <= REG_COUNT);
	endfunction
endpackage

// ===== design/vsg_lsu.sv
// ************************************************
// response buffer
// ************************************************
module vsg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input logic clock_i,
	input logic arst_n_i,
	// fill side
	input logic in_valid_i,
	output logic in_ready_o,
	input logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0] cnt_q;
	logic push;
	logic pop;
	assign in_ready_o = cnt_q != (PW+1)'(DEPTH);
	assign out_valid_o = cnt_q != '0;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_q[rd_q];
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= push ? PW'(wr_q + 1'b1) : wr_q;
			rd_q <= pop ? PW'(rd_q + 1'b1) : rd_q;
			cnt_q <= (PW+1)'(cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
		end
	end
endmodule

// ************************************************
// segment load/store sequencer
// ************************************************
module vsg_lsu (
	// clock and reset
	input logic clock_i,
	input logic arst_n_i,
	// issue
	input logic cmd_valid_i,
	output logic cmd_ready_o,
	input logic cmd_store_i,
	input logic [1:0] cmd_mode_i,
	input logic cmd_fault_first_i,
	input logic cmd_masked_i,
	input logic [2:0] field_count_code_i,
	input logic [1:0] cmd_eew_log_i,
	input logic [1:0] selected_element_width_i,
	input logic [2:0] group_multiplier_i,
	input logic [4:0] dest_vector_reg_i,
	input logic [4:0] store_source_vector_reg_i,
	input logic [4:0] index_vector_reg_i,
	input logic [31:0] base_scalar_reg_i,
	input logic [31:0] stride_scalar_reg_i,
	input logic [7:0] vector_length_i,
	input logic [7:0] vstart_i,
	input logic irq_i,
	// memory
	output logic mem_req_valid_o,
	input logic mem_req_ready_i,
	output logic [31:0] mem_req_addr_o,
	output logic mem_req_we_o,
	output logic [1:0] mem_req_size_o,
	output logic [63:0] mem_req_wdata_o,
	input logic mem_rsp_valid_i,
	output logic mem_rsp_ready_o,
	input logic [63:0] mem_rsp_data_i,
	input logic mem_rsp_fault_i,
	input logic mem_rsp_watch_i,
	// register file read
	output logic vrf_rd_valid_o,
	output logic [4:0] vrf_rd_reg_o,
	output logic [7:0] vrf_rd_elem_o,
	output logic vrf_rd_mask_o,
	output logic [1:0] vrf_rd_eew_o,
	input logic [63:0] vrf_rd_data_i,
	// register file write
	output logic vrf_wr_valid_o,
	input logic vrf_wr_ready_i,
	output logic [4:0] vrf_wr_reg_o,
	output logic [7:0] vrf_wr_elem_o,
	output logic [63:0] vrf_wr_data_o,
	// result
	output logic done_o,
	output logic illegal_o,
	output logic [1:0] trap_kind_o,
	output logic [7:0] vector_length_o,
	output logic [7:0] vstart_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	vsg_pkg::vsg_state_t state_q, state_d, body_st;
	logic store_q, ff_q, masked_q, idx_q;
	logic [1:0] elog_q, ilog_q;
	logic [3:0] nf_q, regs_q;
	logic [4:0] vreg_q, ireg_q;
	logic [31:0] base_q, step_q, seg_addr_q, mreq_addr_q;
	logic [63:0] wdata_q, wr_data_q;
	logic [7:0] vl_q, start_q, seg_q, vl_out_q, vstart_out_q, wr_elem_q;
	logic [2:0] field_q;
	logic rd_valid_q, rd_pend_q, rd_mask_q, mreq_valid_q, mwe_q;
	logic [4:0] rd_reg_q, wr_reg_q;
	logic [1:0] rd_eew_q, msize_q, trap_q;
	logic done_q, illegal_q, wr_valid_q;

	// ************************************************
	// command decode
	// ************************************************
	logic acc, idx_cmd, cfg_ok;
	logic [3:0] nf_cmd, data_regs;
	logic [6:0] data_span;
	logic signed [3:0] group_multiplier_s, ratio_log, data_log;
	logic [4:0] vreg_cmd;
	logic [1:0] elog_cmd;
	logic [31:0] step_cmd;
	assign acc = (state_q == vsg_pkg::ST_IDLE) && cmd_valid_i;
	assign idx_cmd = cmd_mode_i[1];
	assign nf_cmd = vsg_pkg::nf_decode(field_count_code_i);
	assign group_multiplier_s = $signed({group_multiplier_i[2], group_multiplier_i});
	assign ratio_log = 4'($signed({2'b00, cmd_eew_log_i})
		- $signed({2'b00, selected_element_width_i}) + group_multiplier_s);
	assign data_log = idx_cmd ? group_multiplier_s : ratio_log;
	assign vreg_cmd = cmd_store_i ? store_source_vector_reg_i : dest_vector_reg_i;
	assign data_regs = vsg_pkg::grp_regs(data_log);
	assign data_span = 7'(7'(data_regs) * 7'(nf_cmd));
	// reserved checks, data group and index group
	assign cfg_ok = vsg_pkg::grp_ok(vreg_cmd, data_log, nf_cmd)
		&& (!idx_cmd || vsg_pkg::grp_ok(index_vector_reg_i, ratio_log, 4'h1));
	assign elog_cmd = idx_cmd ? selected_element_width_i : cmd_eew_log_i;
	assign step_cmd = (cmd_mode_i == vsg_pkg::MODE_UNIT) ? (32'(nf_cmd) << elog_cmd)
		: (cmd_mode_i == vsg_pkg::MODE_STRIDE) ? stride_scalar_reg_i : 32'h0000_0000;

	// ************************************************
	// sequencing events
	// ************************************************
	logic fifo_in_ready, fifo_in_valid, fifo_out_valid, fifo_out_ready;
	logic [vsg_pkg::FIFO_W-1:0] fifo_out_data;
	logic seg_end, irq_take, rsp_take, rsp_ok, last_field, mask_off, next_seg;
	logic trim, rd_start, rd_state;
	logic [4:0] field_reg, rd_reg_d;
	logic [31:0] field_addr, idx_off;
	// a start index at or past the length moves nothing
	assign seg_end = seg_q >= vl_q;
	// an interrupt is only taken once a segment has completed
	assign irq_take = (state_q == vsg_pkg::ST_SEG) && !seg_end && irq_i && (seg_q != start_q);
	assign rsp_take = (state_q == vsg_pkg::ST_RSP) && mem_rsp_valid_i;
	assign rsp_ok = rsp_take && !mem_rsp_fault_i && !mem_rsp_watch_i;
	assign trim = rsp_take && mem_rsp_fault_i && ff_q && (seg_q != 8'h00);
	assign last_field = field_q == 3'(nf_q - 4'h1);
	assign mask_off = (state_q == vsg_pkg::ST_MASK) && rd_pend_q && !vrf_rd_data_i[0];
	assign next_seg = mask_off || (rsp_ok && last_field);
	assign field_reg = 5'(vreg_q + 5'(8'(field_q) * 8'(regs_q)));
	assign field_addr = seg_addr_q + (32'(field_q) << elog_q);
	assign idx_off = (ilog_q == 2'h0) ? {24'h00_0000, vrf_rd_data_i[7:0]}
		: (ilog_q == 2'h1) ? {16'h0000, vrf_rd_data_i[15:0]} : vrf_rd_data_i[31:0];
	assign body_st = store_q ? vsg_pkg::ST_DATA : vsg_pkg::ST_ISSUE;
	assign rd_state = (state_q == vsg_pkg::ST_MASK) || (state_q == vsg_pkg::ST_INDEX)
		|| (state_q == vsg_pkg::ST_DATA);
	assign rd_start = rd_state && !rd_valid_q && !rd_pend_q;
	assign rd_reg_d = (state_q == vsg_pkg::ST_MASK) ? vsg_pkg::MASK_REG
		: (state_q == vsg_pkg::ST_INDEX) ? ireg_q : field_reg;

	// fields of a segment go out lowest first; any order would do
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			vsg_pkg::ST_IDLE: if (cmd_valid_i) begin
				state_d = cfg_ok ? vsg_pkg::ST_SEG : vsg_pkg::ST_DONE;
			end
			vsg_pkg::ST_SEG: if (seg_end || irq_take) begin
				state_d = vsg_pkg::ST_DONE;
			end else if (masked_q) begin
				state_d = vsg_pkg::ST_MASK;
			end else begin
				state_d = idx_q ? vsg_pkg::ST_INDEX : body_st;
			end
			vsg_pkg::ST_MASK: if (rd_pend_q) begin
				state_d = mask_off ? vsg_pkg::ST_SEG : (idx_q ? vsg_pkg::ST_INDEX : body_st);
			end
			vsg_pkg::ST_INDEX: if (rd_pend_q) begin
				state_d = body_st;
			end
			vsg_pkg::ST_DATA: if (rd_pend_q) begin
				state_d = vsg_pkg::ST_ISSUE;
			end
			vsg_pkg::ST_ISSUE: if (mreq_valid_q && mem_req_ready_i) begin
				state_d = vsg_pkg::ST_RSP;
			end
			vsg_pkg::ST_RSP: if (rsp_take) begin
				state_d = !rsp_ok ? vsg_pkg::ST_DONE : (last_field ? vsg_pkg::ST_SEG : body_st);
			end
			vsg_pkg::ST_DONE: if (!fifo_out_valid && !wr_valid_q) begin
				state_d = vsg_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= vsg_pkg::ST_IDLE;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			done_q <= (state_q == vsg_pkg::ST_DONE) && (state_d == vsg_pkg::ST_IDLE);
		end
	end

	// ************************************************
	// command capture and segment walk
	// ************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{store_q, ff_q, masked_q, idx_q, elog_q, ilog_q} <= '0;
			{nf_q, regs_q, vreg_q, ireg_q, base_q, step_q} <= '0;
			{vl_q, start_q} <= '0;
		end else if (acc) begin
			store_q <= cmd_store_i;
			ff_q <= cmd_fault_first_i && !cmd_store_i;
			masked_q <= cmd_masked_i;
			idx_q <= idx_cmd;
			elog_q <= elog_cmd;
			ilog_q <= cmd_eew_log_i;
			nf_q <= nf_cmd;
			regs_q <= data_regs;
			vreg_q <= vreg_cmd;
			ireg_q <= index_vector_reg_i;
			base_q <= base_scalar_reg_i;
			step_q <= step_cmd;
			vl_q <= vector_length_i;
			start_q <= vstart_i;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			seg_q <= '0;
			field_q <= '0;
			seg_addr_q <= '0;
			wdata_q <= '0;
		end else begin
			if (acc) begin
				seg_q <= vstart_i;
				field_q <= '0;
				seg_addr_q <= base_scalar_reg_i + 32'(step_cmd * 32'(vstart_i));
			end else if (next_seg) begin
				seg_q <= 8'(seg_q + 8'h01);
				field_q <= '0;
				seg_addr_q <= seg_addr_q + step_q;
			end else if (rsp_ok) begin
				field_q <= 3'(field_q + 3'h1);
			end
			if ((state_q == vsg_pkg::ST_INDEX) && rd_pend_q) begin
				seg_addr_q <= base_q + idx_off;
			end
			if ((state_q == vsg_pkg::ST_DATA) && rd_pend_q) begin
				wdata_q <= vrf_rd_data_i;
			end
		end
	end

	// ************************************************
	// register file reads: mask bit, index, store data
	// ************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{rd_valid_q, rd_pend_q, rd_mask_q, rd_reg_q, rd_eew_q} <= '0;
		end else begin
			rd_valid_q <= rd_start;
			rd_pend_q <= rd_valid_q;
			if (rd_start) begin
				rd_reg_q <= rd_reg_d;
				rd_mask_q <= state_q == vsg_pkg::ST_MASK;
				rd_eew_q <= (state_q == vsg_pkg::ST_INDEX) ? ilog_q : elog_q;
			end
		end
	end

	// ************************************************
	// memory requests, one outstanding
	// ************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{mreq_valid_q, mwe_q, msize_q, mreq_addr_q} <= '0;
		end else if ((state_q == vsg_pkg::ST_ISSUE) && !mreq_valid_q && fifo_in_ready) begin
			mreq_valid_q <= 1'b1;
			mreq_addr_q <= field_addr;
			mwe_q <= store_q;
			msize_q <= elog_q;
		end else if (mreq_valid_q && mem_req_ready_i) begin
			mreq_valid_q <= 1'b0;
		end
	end

	// ************************************************
	// completion, traps and length update
	// ************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{illegal_q, trap_q, vl_out_q, vstart_out_q} <= '0;
		end else if (acc) begin
			illegal_q <= !cfg_ok;
			trap_q <= vsg_pkg::TRAP_NONE;
			vl_out_q <= vector_length_i;
			vstart_out_q <= vstart_i;
		end else if (state_q == vsg_pkg::ST_SEG && seg_end) begin
			vstart_out_q <= 8'h00;
		end else if (irq_take) begin
			trap_q <= vsg_pkg::TRAP_IRQ;
			vstart_out_q <= seg_q;
		end else if (trim) begin
			vl_out_q <= seg_q;
			vstart_out_q <= 8'h00;
		end else if (rsp_take && !rsp_ok) begin
			// vector length stays, resume at the segment
			trap_q <= mem_rsp_fault_i ? vsg_pkg::TRAP_FAULT : vsg_pkg::TRAP_DEBUG;
			vstart_out_q <= seg_q;
		end
	end

	// ************************************************
	// load data path: buffer then register file write
	// ************************************************
	assign fifo_in_valid = rsp_ok && !store_q;
	assign fifo_out_ready = !wr_valid_q || vrf_wr_ready_i;
	vsg_fifo #(
		.WIDTH(vsg_pkg::FIFO_W),
		.DEPTH(vsg_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i({field_reg, seg_q, mem_rsp_data_i}),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{wr_valid_q, wr_reg_q, wr_elem_q, wr_data_q} <= '0;
		end else if (fifo_out_valid && fifo_out_ready) begin
			wr_valid_q <= 1'b1;
			{wr_reg_q, wr_elem_q, wr_data_q} <= fifo_out_data;
		end else if (vrf_wr_ready_i) begin
			wr_valid_q <= 1'b0;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	assign cmd_ready_o = state_q[0];
	assign mem_rsp_ready_o = state_q[6];
	assign mem_req_valid_o = mreq_valid_q;
	assign mem_req_addr_o = mreq_addr_q;
	assign mem_req_we_o = mwe_q;
	assign mem_req_size_o = msize_q;
	assign mem_req_wdata_o = wdata_q;
	assign vrf_rd_valid_o = rd_valid_q;
	assign vrf_rd_reg_o = rd_reg_q;
	assign vrf_rd_elem_o = seg_q;
	assign vrf_rd_mask_o = rd_mask_q;
	assign vrf_rd_eew_o = rd_eew_q;
	assign vrf_wr_valid_o = wr_valid_q;
	assign vrf_wr_reg_o = wr_reg_q;
	assign vrf_wr_elem_o = wr_elem_q;
	assign vrf_wr_data_o = wr_data_q;
	assign done_o = done_q;
	assign illegal_o = illegal_q;
	assign trap_kind_o = trap_q;
	assign vector_length_o = vl_out_q;
	assign vstart_o = vstart_out_q;

	// ************************************************
	// checks
	// ************************************************
	sequence s_illegal_end;
		!mem_req_valid_o ##1 (done_o && illegal_o);
	endsequence
	a_illegal_no_access: assert property ((acc && !cfg_ok) |=> s_illegal_end)
		else $error("reserved encoding did not end illegal without access");
	a_nf_decode: assert property (acc |=> nf_q == 4'($past(field_count_code_i)) + 4'h1)
		else $error("field count decode wrong");
	a_span_limit: assert property ((acc && data_span > 7'h08) |-> ##2 (done_o && illegal_o))
		else $error("register span above eight accepted");
	a_range_limit: assert property ((acc && 7'(vreg_cmd) + data_span > 7'h20)
		|=> !mem_req_valid_o ##1 illegal_o)
		else $error("register range past last accepted");
	a_first_trap: assert property ((rsp_take && mem_rsp_fault_i && seg_q == 8'h00)
		|=> (trap_q == vsg_pkg::TRAP_FAULT && vl_out_q == vl_q))
		else $error("element zero fault did not trap with length kept");
	a_ff_trim: assert property (trim
		|=> (vl_out_q == $past(seg_q) && trap_q == vsg_pkg::TRAP_NONE
		&& state_q == vsg_pkg::ST_DONE))
		else $error("late fault did not trim length");
	a_irq_keep: assert property (irq_take
		|=> (trap_q == vsg_pkg::TRAP_IRQ && vl_out_q == vl_q && vstart_out_q == $past(seg_q)))
		else $error("interrupt trap changed length or lost start index");
	a_irq_progress: assert property ((state_q == vsg_pkg::ST_SEG && seg_q == start_q
		&& !seg_end) |=> trap_q != vsg_pkg::TRAP_IRQ)
		else $error("interrupt taken before first segment");
	a_debug_trap: assert property ((rsp_take && !mem_rsp_fault_i && mem_rsp_watch_i)
		|=> (trap_q == vsg_pkg::TRAP_DEBUG && vl_out_q == vl_q))
		else $error("watchpoint did not take debug trap");
	a_mask_skip: assert property (mask_off
		|=> (state_q == vsg_pkg::ST_SEG && seg_q == 8'($past(seg_q) + 8'h01) && !mem_req_valid_o))
		else $error("masked segment not skipped whole");
endmodule

// ===== sim/vsg_mem_model.sv
// ****
// memory and register file partner
// ****
module vsg_mem_model (
	// clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// memory
	input wire logic mem_req_valid_o,
	output logic mem_req_ready_i,
	input wire logic [31:0] mem_req_addr_o,
	output logic mem_rsp_valid_i,
	input wire logic mem_rsp_ready_o,
	output logic [63:0] mem_rsp_data_i,
	output logic mem_rsp_fault_i,
	output logic mem_rsp_watch_i,
	// register file
	input wire logic vrf_rd_valid_o,
	input wire logic [4:0] vrf_rd_reg_o,
	input wire logic [7:0] vrf_rd_elem_o,
	input wire logic vrf_rd_mask_o,
	output logic [63:0] vrf_rd_data_i,
	output logic vrf_wr_ready_i,
	// fault injection
	input wire logic [31:0] fault_addr_i,
	input wire logic [31:0] watch_addr_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] addr_q;
	logic [1:0] wait_q;
	logic busy_q;
	// idle lines carry the inverse so stale data never looks valid
	assign mem_rsp_valid_i = busy_q && (wait_q == 2'h0);
	assign mem_rsp_data_i = mem_rsp_valid_i ? {~addr_q, addr_q} : {addr_q, ~addr_q};
	assign mem_rsp_fault_i = mem_rsp_valid_i && (addr_q == fault_addr_i);
	assign mem_rsp_watch_i = mem_rsp_valid_i && (addr_q == watch_addr_i);
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_q <= 1'b0;
			wait_q <= 2'h0;
			addr_q <= 32'h0000_0000;
			mem_req_ready_i <= 1'b0;
			vrf_wr_ready_i <= 1'b0;
			vrf_rd_data_i <= 64'h0000_0000_0000_0000;
		end else begin
			mem_req_ready_i <= 1'($urandom_range(0, 1));
			vrf_wr_ready_i <= 1'($urandom_range(0, 1));
			if (mem_req_valid_o && mem_req_ready_i) begin
				busy_q <= 1'b1;
				addr_q <= mem_req_addr_o;
				wait_q <= 2'($urandom_range(0, 3));
			end else if (mem_rsp_valid_i && mem_rsp_ready_o) begin
				busy_q <= 1'b0;
			end else if (wait_q != 2'h0) begin
				wait_q <= wait_q - 2'h1;
			end
			if (vrf_rd_valid_o && vrf_rd_mask_o) begin
				vrf_rd_data_i <= 64'(~vrf_rd_elem_o[0]);
			end else if (vrf_rd_valid_o) begin
				vrf_rd_data_i <= 64'({vrf_rd_reg_o, vrf_rd_elem_o, 4'h0});
			end else begin
				vrf_rd_data_i <= ~vrf_rd_data_i;
			end
		end
	end
endmodule

// ===== sim/test_vector_segment_load_store.sv
module test_vector_segment_load_store;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_i, arst_n_i, cmd_valid_i, cmd_ready_o, cmd_store_i, cmd_fault_first_i;
	logic cmd_masked_i, irq_i, mem_req_valid_o, mem_req_ready_i, mem_req_we_o, mem_rsp_valid_i;
	logic mem_rsp_ready_o, mem_rsp_fault_i, mem_rsp_watch_i, vrf_rd_valid_o, vrf_rd_mask_o;
	logic vrf_wr_valid_o, vrf_wr_ready_i, done_o, illegal_o;
	logic [1:0] cmd_mode_i, cmd_eew_log_i, selected_element_width_i, mem_req_size_o;
	logic [1:0] vrf_rd_eew_o, trap_kind_o;
	logic [2:0] field_count_code_i, group_multiplier_i;
	logic [4:0] dest_vector_reg_i, store_source_vector_reg_i, index_vector_reg_i;
	logic [4:0] vrf_rd_reg_o, vrf_wr_reg_o;
	logic [7:0] vector_length_i, vstart_i, vrf_rd_elem_o, vrf_wr_elem_o;
	logic [7:0] vector_length_o, vstart_o;
	logic [31:0] base_scalar_reg_i, stride_scalar_reg_i, mem_req_addr_o;
	logic [31:0] fault_addr_i, watch_addr_i;
	logic [63:0] mem_req_wdata_o, mem_rsp_data_i, vrf_rd_data_i, vrf_wr_data_o;
	int miscompares, n_checks;
	logic [98:0] qm[$];
	logic [76:0] qw[$];
	vsg_lsu u_dut (.*);
	vsg_mem_model u_mdl (.*);
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		if (mem_req_valid_o && mem_req_ready_i)
			qm.push_back({mem_req_size_o, mem_req_we_o, mem_req_addr_o, mem_req_wdata_o});
		if (vrf_wr_valid_o && vrf_wr_ready_i)
			qw.push_back({vrf_wr_reg_o, vrf_wr_elem_o, vrf_wr_data_o});
		if (vrf_rd_valid_o && !vrf_rd_mask_o)
			chk(vrf_rd_eew_o, (cmd_mode_i[1] && vrf_rd_reg_o == 5'h18) ? 2'h2 : 2'h3);
	end
	// ****
	// checking helpers
	// ****
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	function automatic logic [3:0] regs_of(input logic [2:0] lg);
		return ($signed(lg) <= 0) ? 4'h1 : 4'(4'h1 << lg[1:0]);
	endfunction
	function automatic logic legal(input logic [4:0] b, input logic [2:0] lg, input logic [2:0] c);
		int n;
		int r;
		n = int'(c) + 1;
		r = int'(regs_of(lg));
		return ($signed(lg) >= -3) && (r * n <= 8) && (b % r == 0) && (b + r * n <= 32);
	endfunction
	function automatic logic [63:0] vrf_word(input logic [4:0] r, input logic [7:0] e);
		return 64'({r, e, 4'h0});
	endfunction
	function automatic logic [31:0] seg_addr(input int s);
		case (cmd_mode_i)
			2'h0: return base_scalar_reg_i + 32'(s * (int'(field_count_code_i) + 1) * 8);
			2'h1: return base_scalar_reg_i + 32'(s) * stride_scalar_reg_i;
			default: return base_scalar_reg_i + 32'(vrf_word(index_vector_reg_i, 8'(s)));
		endcase
	endfunction
	// one command: issue, wait for completion, compare result and traffic
	task automatic run(input logic [1:0] md, input logic st, ff, mk, input logic [2:0] c, lg,
			input logic [4:0] rg, input logic [7:0] vl, input logic [1:0] tk,
			input logic [7:0] evl, evs);
		logic ill;
		logic [4:0] r;
		logic [31:0] a;
		logic [98:0] m;
		int n;
		ill = !legal(rg, lg, c);
		r = 5'(regs_of(lg));
		qm = {};
		qw = {};
		cmd_mode_i = md;
		cmd_store_i = st;
		cmd_fault_first_i = ff;
		cmd_masked_i = mk;
		field_count_code_i = c;
		group_multiplier_i = lg;
		cmd_eew_log_i = md[1] ? 2'h2 : 2'h3;
		dest_vector_reg_i = st ? rg ^ 5'h10 : rg;
		store_source_vector_reg_i = st ? rg : rg ^ 5'h10;
		vector_length_i = vl;
		cmd_valid_i = 1'b1;
		while (!cmd_ready_o) @(negedge clock_i);
		@(negedge clock_i);
		cmd_valid_i = 1'b0;
		n = 0;
		while (done_o !== 1'b1 && n < 3000) begin
			@(negedge clock_i);
			n++;
		end
		chk(done_o, 1'b1);
		chk(illegal_o, ill);
		if (ill) begin
			chk(qm.size(), 0);
		end else begin
			chk({trap_kind_o, vector_length_o, vstart_o}, {tk, evl, evs});
		end
		if (!ill && tk == 2'h0 && evl == vl) begin
			for (int s = int'(vstart_i); s < int'(vl); s++) begin
				if (mk && s[0]) continue;
				for (int f = 0; f <= int'(c); f++) begin
					a = seg_addr(s) + 32'(f * 8);
					m = qm.pop_front();
					chk(m[98:64], {2'h3, st, a});
					if (st) chk(m[63:0], vrf_word(rg + 5'(f) * r, 8'(s)));
					if (!st) chk(qw.pop_front(), {rg + 5'(f) * r, 8'(s), ~a, a});
				end
			end
			chk(qm.size() + qw.size(), 0);
		end
		$display("test done: mode %0d store %0d fields %0d", md, st, c + 1);
	endtask
	// ****
	// test sequence
	// ****
	initial begin
		logic [7:0] v;
		void'($urandom(9));
		{cmd_valid_i, cmd_store_i, cmd_fault_first_i, cmd_masked_i, irq_i} = '0;
		{cmd_mode_i, field_count_code_i, group_multiplier_i, cmd_eew_log_i} = '0;
		{dest_vector_reg_i, store_source_vector_reg_i, vector_length_i} = '0;
		{base_scalar_reg_i, stride_scalar_reg_i} = '0;
		vstart_i = 8'h00;
		selected_element_width_i = 2'h3;
		index_vector_reg_i = 5'h18;
		fault_addr_i = 32'hffff_ffff;
		watch_addr_i = 32'hffff_ffff;
		arst_n_i = 1'b0;
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
		arst_n_i = 1'b1;
		for (int c = 0; c < 8; c++) begin
			base_scalar_reg_i = 32'h4000_0000 + 32'($urandom_range(0, 255) * 8);
			run(2'h0, 1'b0, 1'b0, 1'b0, 3'(c), 3'h0, 5'h08, 8'h03, 2'h0, 8'h03, 8'h00);
		end
		repeat (40) begin
			run(2'h0, 1'($urandom), 1'b0, 1'b0, 3'($urandom), 3'($urandom), 5'($urandom),
				8'h01, 2'h0, 8'h01, 8'h00);
		end
		repeat (16) begin
			v = 8'($urandom_range(1, 6));
			base_scalar_reg_i = 32'h4000_0000 + 32'($urandom_range(0, 4095) * 8);
			stride_scalar_reg_i = (32'($urandom_range(0, 16)) - 32'h0000_0008) << 4;
			run(2'($urandom_range(0, 3)), 1'($urandom), 1'b0, 1'($urandom),
				3'($urandom_range(0, 3)), 3'($urandom_range(0, 1)), 5'h08, v, 2'h0, v,
				8'h00);
		end
		vstart_i = 8'h02;
		run(2'h0, 1'b0, 1'b0, 1'b0, 3'h1, 3'h0, 5'h08, 8'h05, 2'h0, 8'h05, 8'h00);
		vstart_i = 8'h00;
		base_scalar_reg_i = 32'h4000_1000;
		fault_addr_i = 32'h4000_1020;
		run(2'h0, 1'b0, 1'b1, 1'b0, 3'h1, 3'h0, 5'h08, 8'h05, 2'h0, 8'h02, 8'h00);
		fault_addr_i = 32'h4000_1008;
		run(2'h0, 1'b0, 1'b1, 1'b0, 3'h1, 3'h0, 5'h08, 8'h05, 2'h1, 8'h05, 8'h00);
		fault_addr_i = 32'h4000_1030;
		run(2'h0, 1'b0, 1'b0, 1'b0, 3'h1, 3'h0, 5'h08, 8'h05, 2'h1, 8'h05, 8'h03);
		fault_addr_i = 32'hffff_ffff;
		watch_addr_i = 32'h4000_1020;
		run(2'h0, 1'b0, 1'b1, 1'b0, 3'h1, 3'h0, 5'h08, 8'h05, 2'h3, 8'h05, 8'h02);
		watch_addr_i = 32'hffff_ffff;
		irq_i = 1'b1;
		run(2'h0, 1'b0, 1'b1, 1'b0, 3'h1, 3'h0, 5'h08, 8'h05, 2'h2, 8'h05, 8'h01);
		irq_i = 1'b0;
		print_verdict();
	end
	// about 70 commands of at most a few hundred cycles each
	initial begin
		#500us;
		miscompares++;
		print_verdict();
	end
endmodule
